//--- design/acttc_pkg.sv
// Package for the 16-bit timer/counter: register map, fields, reset values.
// Assumes a 32-bit APB slave with byte-wide registers in the low data bits.
package acttc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_INTERRUPT_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_COUNT_LOW_BYTE = 8'h0e;
  localparam logic [7:0] IDX_COUNT_HIGH_BYTE = 8'h0f;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] IDX_PERIPHERAL_INTERRUPT_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_COMPARE_LOW = 8'h15;
  localparam logic [7:0] IDX_COMPARE_HIGH = 8'h16;
  localparam logic [7:0] IDX_COMPARE_CONTROL = 8'h17;
  // Field positions
  localparam int RUN_ENABLE_POS = 0;
  localparam int SOURCE_SELECT_POS = 1;
  localparam int SYNC_BYPASS_POS = 2;
  localparam int OSC_ENABLE_POS = 3;
  localparam int PRESCALE_LSB = 4;
  localparam int OVERFLOW_POS = 0;
  localparam int GLOBAL_IE_POS = 7;
  localparam int PERIPH_IE_POS = 6;
  // Reset values
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hb;
  localparam int PHASES = 4;
  typedef struct packed {
    logic [1:0] prescale;
    logic osc_enable;
    logic sync_bypass;
    logic source_select;
    logic run_enable;
  } acttc_ctrl_type;
  typedef enum logic [1:0] {ACTTC_Q1, ACTTC_Q2, ACTTC_Q3, ACTTC_Q4} acttc_phase_type;
endpackage

//--- design/acttc_timer.sv
// 16-bit timer/counter with prescaler, sync/async external count, compare reset.
// Assumes pclk is the instruction oscillator; pins arrive asynchronously.
//
// Overview of operation
// - Count wraps from all ones to zero and sets the overflow flag.
// - Prescale field divides the count input by 1, 2, 4 or 8.
// - Source bit picks internal instruction clock or external rising edges.
// - Counter advances only while the run enable bit is set.
// - Sync mode samples prescaler output on second and fourth phases.
// - Increment happens a little after synchronization completes.
// - Ratios above 1:1 use a symmetrical ripple prescaler before sync.
// - Bypass bit counts the external input without phase synchronization.
// - Asynchronous counting continues in sleep and can wake the core.
// - Asynchronous counting is no time base for capture or compare.
// - Byte reads during asynchronous counting return stable values.
// - Oscillator enable bit starts the crystal oscillator, kept in sleep.
// - Compare mode 1011 special event trigger resets the counter.
// - Trigger reset does not set the overflow flag.
// - Trigger reset is guaranteed only in internal or synchronized counting.
// - A count write wins over a coinciding trigger.
// - Compare register pair acts as the counter period.
// - Count bytes are untouched by reset; only the trigger clears them.
// - Control register clears on power-on reset; timer stopped, 1:1.
// - Any write to a count byte clears the prescaler.
`timescale 1ns/1ps
`default_nettype none
module acttc_timer
  import acttc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic crystal_input_pin,
  input wire logic sleep_active,
  output logic crystal_output_pin,
  output logic crystal_output_pin_oe_n,
  output logic osc_enable_out,
  output logic interrupt_request,
  output logic wake_request,
  output logic timebase_valid,
  output logic [15:0] count_out
);
  // ==========================================================
  // Bus decode
  acttc_ctrl_type ctrl_q;
  logic [15:0] count_q;
  logic [15:0] compare_q;
  logic [3:0] compare_mode_q;
  logic [7:0] flags_q;
  logic [7:0] enables_q;
  logic [7:0] intctl_q;
  logic [2:0] prescale_q;
  logic access_fire;
  logic wr_fire;
  logic [7:0] reg_index;
  logic known_addr;

  function automatic logic idx_hit(input logic [7:0] idx, input logic [7:0] ref_idx);
    idx_hit = (idx == ref_idx);
  endfunction

  assign access_fire = psel && penable;
  // Write lands once, on the first access edge, not again in the ready cycle
  assign wr_fire = access_fire && !pready && pwrite && pstrb[0];
  assign reg_index = paddr[9:2];
  assign known_addr = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000) &&
    (idx_hit(reg_index, IDX_INTERRUPT_CONTROL) ||
     idx_hit(reg_index, IDX_PERIPHERAL_INTERRUPT_FLAGS) ||
     idx_hit(reg_index, IDX_COUNT_LOW_BYTE) || idx_hit(reg_index, IDX_COUNT_HIGH_BYTE) ||
     idx_hit(reg_index, IDX_TIMER_CONTROL) ||
     idx_hit(reg_index, IDX_PERIPHERAL_INTERRUPT_ENABLES) ||
     idx_hit(reg_index, IDX_COMPARE_LOW) || idx_hit(reg_index, IDX_COMPARE_HIGH) ||
     idx_hit(reg_index, IDX_COMPARE_CONTROL));

  logic wr_low;
  logic wr_high;
  logic wr_count;
  assign wr_low = wr_fire && known_addr && idx_hit(reg_index, IDX_COUNT_LOW_BYTE);
  assign wr_high = wr_fire && known_addr && idx_hit(reg_index, IDX_COUNT_HIGH_BYTE);
  assign wr_count = wr_low || wr_high;

  // ==========================================================
  // Input synchronizers and phase clock
  logic [1:0] ext_sync_q;
  logic [1:0] xtal_sync_q;
  logic ext_level;
  acttc_phase_type phase_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_q <= 2'h0;
      xtal_sync_q <= 2'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], external_count_pin};
      xtal_sync_q <= {xtal_sync_q[0], crystal_input_pin};
    end
  end

  // Crystal input feeds the count when the oscillator runs
  assign ext_level = ctrl_q.osc_enable ? xtal_sync_q[1] : ext_sync_q[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= ACTTC_Q1;
    end else begin
      unique case (phase_q)
        ACTTC_Q1: phase_q <= ACTTC_Q2;
        ACTTC_Q2: phase_q <= ACTTC_Q3;
        ACTTC_Q3: phase_q <= ACTTC_Q4;
        ACTTC_Q4: phase_q <= ACTTC_Q1;
      endcase
    end
  end

  // ==========================================================
  // Prescaler: a ripple-style divider on the selected source ticks, held symmetrical
  logic ext_prev_q;
  logic ext_rise;
  logic tick_src;
  logic pre_out;
  logic pre_prev_q;
  logic pre_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_level;
    end
  end
  assign ext_rise = ext_level && !ext_prev_q;

  // Internal mode ticks once per instruction cycle
  assign tick_src = ctrl_q.source_select ? ext_rise : (phase_q == ACTTC_Q4);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= 3'h0;
    end else if (wr_count) begin
      prescale_q <= 3'h0;
    end else if (tick_src) begin
      prescale_q <= prescale_q + 3'h1;
    end
  end

  // Output bit toggles symmetrically at half the selected ratio
  always_comb begin
    unique case (ctrl_q.prescale)
      2'h0: pre_out = ctrl_q.source_select ? ext_level : tick_src;
      2'h1: pre_out = prescale_q[0];
      2'h2: pre_out = prescale_q[1];
      2'h3: pre_out = prescale_q[2];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_prev_q <= 1'b0;
    end else begin
      pre_prev_q <= pre_out;
    end
  end
  assign pre_rise = pre_out && !pre_prev_q;

  // ==========================================================
  // Synchronized path: sample on second and fourth phases, then count
  logic samp_q2_q;
  logic samp_q4_q;
  logic samp_prev_q;
  logic sync_edge;
  logic inc_pending_q;
  logic do_inc;
  logic async_mode;

  assign async_mode = ctrl_q.source_select && ctrl_q.sync_bypass;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q2_q <= 1'b0;
      samp_q4_q <= 1'b0;
      samp_prev_q <= 1'b0;
    end else begin
      if (phase_q == ACTTC_Q2) begin
        samp_q2_q <= pre_out;
      end
      if (phase_q == ACTTC_Q4) begin
        samp_q4_q <= samp_q2_q;
        samp_prev_q <= samp_q4_q;
      end
    end
  end
  assign sync_edge = (phase_q == ACTTC_Q4) && samp_q4_q && !samp_prev_q;

  // Increment lands one cycle after sync completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_pending_q <= 1'b0;
    end else begin
      inc_pending_q <= sync_edge && !sleep_active;
    end
  end

  // Internal mode uses prescaler edges; external sync uses sampled edge.
  // Async mode counts prescaler edges directly and keeps going in sleep.
  always_comb begin
    if (!ctrl_q.run_enable) begin
      do_inc = 1'b0;
    end else if (!ctrl_q.source_select) begin
      do_inc = pre_rise && !sleep_active;
    end else if (async_mode) begin
      do_inc = pre_rise;
    end else begin
      do_inc = inc_pending_q;
    end
  end

  // ==========================================================
  // Compare unit: special event trigger at period match
  logic trig;
  assign trig = (compare_mode_q == SPECIAL_EVENT_MODE) && !async_mode &&
    ctrl_q.run_enable && (count_q == compare_q);

  // ==========================================================
  // Count register; no reset by design, trigger clears it
  always_ff @(posedge pclk) begin
    if (wr_low) begin
      count_q[7:0] <= pwdata[7:0];
    end else if (trig) begin
      count_q[7:0] <= 8'h00;
    end else if (do_inc) begin
      count_q[7:0] <= count_q[7:0] + 8'h01;
    end
    if (wr_high) begin
      count_q[15:8] <= pwdata[7:0];
    end else if (trig && !wr_low) begin
      count_q[15:8] <= 8'h00;
    end else if (do_inc && !wr_low && (count_q[7:0] == 8'hff)) begin
      count_q[15:8] <= count_q[15:8] + 8'h01;
    end
  end

  // Count is unknown until loaded, so checks on it wait for both bytes
  logic [1:0] count_known_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_known_q <= 2'h0;
    end else begin
      count_known_q <= count_known_q | {wr_high || trig, wr_low || trig};
    end
  end

  // ==========================================================
  // Control, compare, interrupt registers
  logic overflow_evt;
  assign overflow_evt = do_inc && !trig && !wr_count && (count_q == 16'hffff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= acttc_ctrl_type'(TIMER_CONTROL_RESET[5:0]);
      enables_q <= ENABLES_RESET;
      intctl_q <= INTCTL_RESET;
      compare_q <= 16'h0000;
      compare_mode_q <= 4'h0;
    end else if (wr_fire && known_addr) begin
      if (idx_hit(reg_index, IDX_TIMER_CONTROL)) begin
        ctrl_q <= acttc_ctrl_type'(pwdata[5:0]);
      end
      if (idx_hit(reg_index, IDX_PERIPHERAL_INTERRUPT_ENABLES)) begin
        enables_q <= pwdata[7:0];
      end
      if (idx_hit(reg_index, IDX_INTERRUPT_CONTROL)) begin
        intctl_q <= pwdata[7:0];
      end
      if (idx_hit(reg_index, IDX_COMPARE_LOW)) begin
        compare_q[7:0] <= pwdata[7:0];
      end
      if (idx_hit(reg_index, IDX_COMPARE_HIGH)) begin
        compare_q[15:8] <= pwdata[7:0];
      end
      if (idx_hit(reg_index, IDX_COMPARE_CONTROL)) begin
        compare_mode_q <= pwdata[3:0];
      end
    end
  end

  // Overflow event wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      if (wr_fire && known_addr && idx_hit(reg_index, IDX_PERIPHERAL_INTERRUPT_FLAGS)) begin
        flags_q <= pwdata[7:0];
      end
      if (overflow_evt) begin
        flags_q[OVERFLOW_POS] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // APB answer and outputs, all registered
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (idx_hit(reg_index, IDX_INTERRUPT_CONTROL)) rd_byte = intctl_q;
    if (idx_hit(reg_index, IDX_PERIPHERAL_INTERRUPT_FLAGS)) rd_byte = flags_q;
    if (idx_hit(reg_index, IDX_COUNT_LOW_BYTE)) rd_byte = count_q[7:0];
    if (idx_hit(reg_index, IDX_COUNT_HIGH_BYTE)) rd_byte = count_q[15:8];
    if (idx_hit(reg_index, IDX_TIMER_CONTROL)) rd_byte = {2'h0, ctrl_q};
    if (idx_hit(reg_index, IDX_PERIPHERAL_INTERRUPT_ENABLES)) rd_byte = enables_q;
    if (idx_hit(reg_index, IDX_COMPARE_LOW)) rd_byte = compare_q[7:0];
    if (idx_hit(reg_index, IDX_COMPARE_HIGH)) rd_byte = compare_q[15:8];
    if (idx_hit(reg_index, IDX_COMPARE_CONTROL)) rd_byte = {4'h0, compare_mode_q};
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access_fire && !pready;
      pslverr <= access_fire && !pready && !known_addr;
      prdata <= (access_fire && !pready && known_addr) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  logic irq_d;
  assign irq_d = flags_q[OVERFLOW_POS] && enables_q[OVERFLOW_POS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request <= 1'b0;
      wake_request <= 1'b0;
      timebase_valid <= 1'b0;
      osc_enable_out <= 1'b0;
      crystal_output_pin <= 1'b0;
      crystal_output_pin_oe_n <= 1'b1;
      count_out <= 16'h0000;
    end else begin
      interrupt_request <= irq_d && intctl_q[PERIPH_IE_POS] && intctl_q[GLOBAL_IE_POS];
      wake_request <= irq_d && sleep_active;
      timebase_valid <= !async_mode;
      osc_enable_out <= ctrl_q.osc_enable;
      crystal_output_pin <= !xtal_sync_q[1];
      crystal_output_pin_oe_n <= !ctrl_q.osc_enable;
      count_out <= count_q;
    end
  end

  // ==========================================================
  // Checks
  sequence s_access;
    psel && penable && !pready;
  endsequence
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_access |=> pready) else $error("ready late");
  chk_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (&count_known_q && !ctrl_q.run_enable && !wr_count && !trig) |=> $stable(count_q))
    else $error("count moved while stopped");
  chk_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_evt |=> (count_q == 16'h0000) && flags_q[OVERFLOW_POS])
    else $error("wrap lost");
  chk_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (trig && !wr_count) |=> count_q == 16'h0000) else $error("trigger no clear");
  chk_trig_noflag: assert property (@(posedge pclk) disable iff (!presetn)
    (trig && !flags_q[OVERFLOW_POS]) |=> !flags_q[OVERFLOW_POS])
    else $error("trigger set flag");
  chk_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (trig && wr_low) |=> count_q[7:0] == $past(pwdata[7:0])) else $error("write lost");
  chk_pre_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_count |=> prescale_q == 3'h0) else $error("prescaler kept");
  chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_d && intctl_q[7] && intctl_q[6]) |=> interrupt_request)
    else $error("irq missing");
  chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_edge && !sleep_active) |=> inc_pending_q) else $error("sync inc lost");
endmodule
`default_nettype wire

//--- sim/acttc_ext_source.sv
// External count source and crystal model facing the timer's pins.
// Assumes a pulse request is not repeated before its pulses are out.
`timescale 1ns/1ps
`default_nettype none
module acttc_ext_source (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] pulses,
  input wire logic osc_on,
  output logic ext_pin,
  output logic xtal_pin
);
  // ==========
  // Count pulses
  // Four oscillator periods high and low, above the two-period minimum
  initial begin
    ext_pin = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        for (int k = 0; k < int'(pulses); k++) begin
          ext_pin <= 1'b1;
          repeat (4) @(posedge pclk);
          ext_pin <= 1'b0;
          repeat (4) @(posedge pclk);
        end
      end
    end
  end
  // ==========
  // Crystal
  // Swings only while enabled, otherwise held low
  always @(posedge pclk) begin
    xtal_pin <= osc_on & ~xtal_pin;
  end
endmodule
`default_nettype wire

//--- sim/async_capable_16bit_timer_counter_tb.sv
// Self-checking bench for the 16-bit timer/counter over APB.
// Assumes the external source model drives the count and crystal pins.
`timescale 1ns/1ps
`default_nettype none
module async_capable_16bit_timer_counter_tb
  import acttc_pkg::*;
;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, sleep_active = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] npulse = 8'h00, r8;
  logic pready, pslverr, ext_pin, xtal_pin, xtal_out, xtal_oe_n, osc_on, irq, wake, tbv, e1;
  logic [15:0] count_out, v;
  int error_cnt = 0, checks = 0;
  typedef struct {logic [7:0] ctrl; logic [7:0] n; logic [15:0] exp;} acttc_row_type;
  acttc_row_type rows[6] = '{'{8'h03, 8'h10, 16'h0010}, '{8'h13, 8'h10, 16'h0008},
    '{8'h23, 8'h10, 16'h0004}, '{8'h33, 8'h18, 16'h0003}, '{8'h07, 8'h0a, 16'h000a},
    '{8'h02, 8'h0a, 16'h0000}};

  acttc_timer i_acttc_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
    .crystal_input_pin(xtal_pin), .sleep_active(sleep_active),
    .crystal_output_pin(xtal_out), .crystal_output_pin_oe_n(xtal_oe_n),
    .osc_enable_out(osc_on), .interrupt_request(irq), .wake_request(wake),
    .timebase_valid(tbv), .count_out(count_out));
  acttc_ext_source i_acttc_ext_source (.pclk(pclk), .go(go), .pulses(npulse),
    .osc_on(osc_on), .ext_pin(ext_pin), .xtal_pin(xtal_pin));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========
  // Helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    d = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
  endtask

  task automatic read_count(output logic [15:0] c);
    logic [7:0] h1, l, h2;
    rd(IDX_COUNT_HIGH_BYTE, h1);
    rd(IDX_COUNT_LOW_BYTE, l);
    rd(IDX_COUNT_HIGH_BYTE, h2);
    if (h1 !== h2) rd(IDX_COUNT_LOW_BYTE, l);
    c = {h2, l};
  endtask

  // Count bytes are only written with the timer stopped; source already final,
  // so with an external source the internal tick cannot advance the prescaler after its clear
  task automatic start(input logic [15:0] c, input logic [7:0] ctrl);
    wr(IDX_TIMER_CONTROL, ctrl & 8'hfe);
    wr(IDX_COUNT_LOW_BYTE, c[7:0]);
    wr(IDX_COUNT_HIGH_BYTE, c[15:8]);
    wr(IDX_TIMER_CONTROL, ctrl);
  endtask

  task automatic pulse(input logic [7:0] n);
    go <= 1'b1;
    npulse <= n;
    @(posedge pclk);
    go <= 1'b0;
    repeat (int'(n) * 8 + 12) @(posedge pclk);
  endtask

  // ==========
  // Sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_TIMER_CONTROL, r8);
    chk("control reset", {8'h00, r8}, 16'h0000);
    rd(IDX_PERIPHERAL_INTERRUPT_ENABLES, r8);
    chk("enables reset", {8'h00, r8}, 16'h0000);
    apb(1'b0, 8'h01, 8'h00, r8, e1);
    chk("unmapped", {7'h00, e1, r8}, 16'h0100);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      start(16'h0000, rows[i].ctrl);
      pulse(rows[i].n);
      wr(IDX_TIMER_CONTROL, rows[i].ctrl & 8'hfe);
      read_count(v);
      chk("row count", v, rows[i].exp);
      chk("count port", count_out, rows[i].exp);
    end
    $display("test table done");
    start(16'h0000, 8'h01);
    repeat (400) @(posedge pclk);
    wr(IDX_TIMER_CONTROL, 8'h00);
    read_count(v);
    chk("internal rate", {15'h0, v >= 16'h0062 && v <= 16'h0068}, 16'h0001);
    start(16'h0000, 8'h23);
    pulse(8'h03);
    start(16'h0000, 8'h23);
    pulse(8'h02);
    wr(IDX_TIMER_CONTROL, 8'h22);
    read_count(v);
    chk("prescaler clear", v, 16'h0001);
    $display("test internal and prescaler done");
    wr(IDX_PERIPHERAL_INTERRUPT_ENABLES, 8'h01);
    wr(IDX_INTERRUPT_CONTROL, 8'hc0);
    sleep_active <= 1'b1;
    start(16'hfffe, 8'h07);
    pulse(8'h02);
    chk("wake", {15'h0, wake}, 16'h0001);
    chk("irq", {15'h0, irq}, 16'h0001);
    sleep_active <= 1'b0;
    wr(IDX_TIMER_CONTROL, 8'h00);
    read_count(v);
    chk("wrap", v, 16'h0000);
    rd(IDX_PERIPHERAL_INTERRUPT_FLAGS, r8);
    chk("overflow flag", {15'h0, r8[0]}, 16'h0001);
    wr(IDX_PERIPHERAL_INTERRUPT_FLAGS, 8'h00);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    $display("test overflow done");
    wr(IDX_COMPARE_LOW, 8'h05);
    wr(IDX_COMPARE_HIGH, 8'h00);
    wr(IDX_COMPARE_CONTROL, {4'h0, SPECIAL_EVENT_MODE});
    start(16'h0000, 8'h03);
    chk("timebase sync", {15'h0, tbv}, 16'h0001);
    pulse(8'h08);
    wr(IDX_TIMER_CONTROL, 8'h00);
    read_count(v);
    chk("trigger period", v, 16'h0003);
    rd(IDX_PERIPHERAL_INTERRUPT_FLAGS, r8);
    chk("trigger no flag", {15'h0, r8[0]}, 16'h0000);
    start(16'h0000, 8'h07);
    chk("timebase async", {15'h0, tbv}, 16'h0000);
    pulse(8'h08);
    wr(IDX_TIMER_CONTROL, 8'h00);
    read_count(v);
    chk("async no trigger", v, 16'h0008);
    $display("test trigger done");
    wr(IDX_TIMER_CONTROL, 8'h08);
    chk("osc enable", {14'h0, osc_on, xtal_oe_n}, 16'h0002);
    // Start-up allowance before the crystal is trusted
    repeat (50) @(posedge pclk);
    r8[0] = xtal_out;
    @(posedge pclk);
    chk("crystal drive", {15'h0, xtal_out}, {15'h0, ~r8[0]});
    start(16'h1234, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'h38);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_TIMER_CONTROL, r8);
    chk("control after reset", {8'h00, r8}, 16'h0000);
    read_count(v);
    chk("count kept", v, 16'h1234);
    $display("test oscillator and reset done");
    summarize();
  end
endmodule
`default_nettype wire
